// *** pkg/flash_lock_consts.vh ***
`ifndef FLASH_LOCK_CONSTS_VH
`define FLASH_LOCK_CONSTS_VH

// flash command codes, low halfword of a write
`define CMD_READ_ARRAY   16'hffff
`define CMD_PAGE_PROG    16'h4141
`define CMD_LOCK_PROG    16'h7777
`define CMD_BLOCK_ERASE  16'h2020
`define CMD_ERASE_ALL    16'ha7a7
`define CMD_READ_STATUS  16'h7070
`define CMD_CLEAR_STATUS 16'h5050
`define CMD_READ_LOCK    16'h7171
`define CMD_VERIFY       16'hd0d0

// last even address of each block
`define BLK0_LAST  20'h03ffe
`define BLK1_LAST  20'h05ffe
`define BLK2_LAST  20'h07ffe
`define BLK3_LAST  20'h0fffe
`define BLK4_LAST  20'h1fffe
`define BLK5_LAST  20'h2fffe
`define BLK6_LAST  20'h3fffe
`define BLK7_LAST  20'h4fffe
`define BLK8_LAST  20'h5fffe
`define BLK9_LAST  20'h6fffe
`define BLK10_LAST 20'h7fffe
`define NUM_BLOCKS 11

// lock status word fields
`define LOCK_LOW_BIT  1
`define LOCK_COPY_BIT 9

// register space select and offsets
`define REG_SPACE_BIT   23
`define REG_CTRL_TWO    8'h00
`define REG_READY_WORD  8'h04
`define REG_ERROR_WORD  8'h08
`define OVERRIDE_BIT    0
`define READY_BIT       7
`define ERASE_FAIL_BIT  5
`define PROG_FAIL1_BIT  4
`define PROG_FAIL2_BIT  3

// timing
`define CLK_MHZ        22'h28
`define PROG_TIME_US   22'h1f40
`define ERASE_TIME_US  22'hc350

`endif

// *** rtl/flash_lock_bit_sequencer.v ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_lock_consts.vh"

module flash_lock_bit_sequencer #(
	parameter        NBLK         = `NUM_BLOCKS,
	parameter [21:0] PROG_CYCLES  = `PROG_TIME_US * `CLK_MHZ,
	parameter [21:0] ERASE_CYCLES = `ERASE_TIME_US * `CLK_MHZ
) (
	input  wire        SYS_CLK,
	input  wire        RST_B,
	input  wire [31:0] ADR_I,
	input  wire [31:0] DAT_I,
	input  wire [3:0]  SEL_I,
	input  wire        WE_I,
	input  wire        CYC_I,
	input  wire        STB_I,
	output reg  [31:0] DAT_O,
	output reg         ACK_O
);

////////////////////////////////////////////////////////////////////////
// states, operations and read modes

// one-hot sequencer states
localparam [3:0] ST_IDLE = 4'h1;
localparam [3:0] ST_VFY  = 4'h2;
localparam [3:0] ST_DATA = 4'h4;
localparam [3:0] ST_BUSY = 4'h8;

// operation waiting for confirmation or running
localparam [1:0] OP_LOCK  = 2'h0;
localparam [1:0] OP_ERASE = 2'h1;
localparam [1:0] OP_EALL  = 2'h2;
localparam [1:0] OP_PROG  = 2'h3;

// what a flash-space read returns
localparam [1:0] RD_ARRAY  = 2'h0;
localparam [1:0] RD_STATUS = 2'h1;
localparam [1:0] RD_LOCK   = 2'h2;

////////////////////////////////////////////////////////////////////////
// storage

// sequencer state and the operation it carries
reg  [3:0]      state;
reg  [1:0]      op;
reg  [1:0]      mode;
reg  [3:0]      tblk;
reg  [21:0]     timer;

// software-visible control and failure flags
reg             override;
reg             erase_fail;
reg             prog_fail_one;
reg             prog_fail_two;

// one nonvolatile lock cell per block
reg  [NBLK-1:0] lock;

// bus decode
wire            go;
wire            take;
wire            wr_flash;
wire            wr_reg;
wire [15:0]     cmd;
wire [19:0]     faddr;
wire [7:0]      roff;

// block lookup and status
wire [3:0]      ablk;
wire            is_sel;
wire            alocked;
wire            err_any;
wire            ready_flag;
wire            fin;
wire [15:0]     lock_word;
wire [15:0]     error_word;

////////////////////////////////////////////////////////////////////////
// block address map

// last even address of block i
function [19:0] blk_last;
	input [3:0] i;
	begin
		case (i)
		4'h0:    blk_last = `BLK0_LAST;
		4'h1:    blk_last = `BLK1_LAST;
		4'h2:    blk_last = `BLK2_LAST;
		4'h3:    blk_last = `BLK3_LAST;
		4'h4:    blk_last = `BLK4_LAST;
		4'h5:    blk_last = `BLK5_LAST;
		4'h6:    blk_last = `BLK6_LAST;
		4'h7:    blk_last = `BLK7_LAST;
		4'h8:    blk_last = `BLK8_LAST;
		4'h9:    blk_last = `BLK9_LAST;
		4'ha:    blk_last = `BLK10_LAST;
		default: blk_last = 20'hfffff;
		endcase
	end
endfunction

// lowest block whose range holds the address
function [3:0] blk_of;
	input [19:0] a;
	integer k;
	begin
		blk_of = 4'h0;
		for (k = NBLK - 1; k >= 0; k = k - 1) begin
			if (a <= blk_last(k[3:0]))
				blk_of = k[3:0];
		end
	end
endfunction

////////////////////////////////////////////////////////////////////////
// decode

// a request is answered one edge after it is taken
assign go       = CYC_I & STB_I & ~ACK_O;

// writes act at the ack edge, while the master still holds the request,
// so no write lands before the edge that acknowledges it
assign take     = CYC_I & STB_I & ACK_O & WE_I;
assign wr_flash = take & ~ADR_I[`REG_SPACE_BIT];
assign wr_reg   = take & ADR_I[`REG_SPACE_BIT];

// command and address fields
assign cmd      = DAT_I[15:0];
assign faddr    = ADR_I[19:0];
assign roff     = ADR_I[7:0];

// an address past the last block falls to block 0 and never selects
assign ablk     = blk_of(faddr);
assign is_sel   = (faddr == blk_last(ablk));
assign alocked  = ~lock[ablk];

// busy ends on the edge where the counter has run out
assign err_any  = erase_fail | prog_fail_one | prog_fail_two;
assign ready_flag = ~state[3];
assign fin      = state[3] & (timer == 22'h0);

// unassigned positions read as zero; no write path exists
assign lock_word = {
	6'h0,
	lock[ablk],
	7'h0,
	lock[ablk],
	1'b0
};

// error word, also what a flash read returns in status mode
assign error_word = {
	8'h0,
	ready_flag,
	1'b0,
	erase_fail,
	prog_fail_one,
	prog_fail_two,
	3'h0
};

////////////////////////////////////////////////////////////////////////
// lock flags: no reset term, they model nonvolatile cells

// factory state of the cells is erased, i.e. unprotected
initial lock = {NBLK{1'b1}};

// only a finished operation touches the flags; the change lands on the
// edge that raises ready, so a poll that sees ready sees the new flag
always @(posedge SYS_CLK) begin
	if (fin) begin
		case (op)
		OP_LOCK:  lock[tblk] <= 1'b0;
		OP_ERASE: lock[tblk] <= 1'b1;
		OP_EALL: begin
			// erase-all clears every lock only under override
			if (override)
				lock <= {NBLK{1'b1}};
		end
		default: lock <= lock;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// command sequencer

always @(posedge SYS_CLK or negedge RST_B) begin
	if (!RST_B) begin
		state         <= ST_IDLE;
		op            <= OP_LOCK;
		mode          <= RD_ARRAY;
		tblk          <= 4'h0;
		timer         <= 22'h0;
		erase_fail    <= 1'b0;
		prog_fail_one <= 1'b0;
		prog_fail_two <= 1'b0;
	end else begin
		case (state)
		// commands that start an operation, steer reads or clear the status flags
		ST_IDLE: begin
			if (wr_flash) begin
				case (cmd)
				`CMD_READ_ARRAY:  mode <= RD_ARRAY;
				`CMD_READ_STATUS: mode <= RD_STATUS;
				`CMD_READ_LOCK:   mode <= RD_LOCK;
				`CMD_PAGE_PROG:   state <= ST_DATA;
				`CMD_LOCK_PROG: begin
					op    <= OP_LOCK;
					state <= ST_VFY;
				end
				`CMD_BLOCK_ERASE: begin
					op    <= OP_ERASE;
					state <= ST_VFY;
				end
				`CMD_ERASE_ALL: begin
					op    <= OP_EALL;
					state <= ST_VFY;
				end
				`CMD_CLEAR_STATUS: begin
					erase_fail    <= 1'b0;
					prog_fail_one <= 1'b0;
					prog_fail_two <= 1'b0;
				end
				default: state <= ST_IDLE;
				endcase
			end
		end
		// second write of a two-step command
		ST_VFY: begin
			if (wr_flash) begin
				state <= ST_IDLE;
				tblk  <= ablk;
				if (cmd == `CMD_READ_ARRAY) begin
					// cancel without error
					mode <= RD_ARRAY;
				end else if (cmd != `CMD_VERIFY) begin
					// any other code aborts with an error
					if (op == OP_LOCK)
						prog_fail_two <= 1'b1;
					else
						erase_fail <= 1'b1;
				end else if (err_any) begin
					state <= ST_IDLE;
				end else if (op != OP_EALL && !is_sel) begin
					// confirmation outside a selector address
					if (op == OP_LOCK)
						prog_fail_two <= 1'b1;
					else
						erase_fail <= 1'b1;
				end else if (op == OP_ERASE && alocked && !override) begin
					erase_fail <= 1'b1;
				end else begin
					state <= ST_BUSY;
					if (op == OP_LOCK)
						timer <= PROG_CYCLES - 22'h1;
					else
						timer <= ERASE_CYCLES - 22'h1;
				end
			end
		end
		// the first data write starts the page
		ST_DATA: begin
			if (wr_flash) begin
				mode  <= RD_STATUS;
				state <= ST_IDLE;
				tblk  <= ablk;
				op    <= OP_PROG;
				if (err_any) begin
					state <= ST_IDLE;
				end else if (alocked && !override) begin
					prog_fail_one <= 1'b1;
				end else begin
					state <= ST_BUSY;
					timer <= PROG_CYCLES - 22'h1;
				end
			end
		end
		ST_BUSY: begin
			// flash writes while busy are acknowledged and dropped
			if (timer == 22'h0)
				state <= ST_IDLE;
			else
				timer <= timer - 22'h1;
		end
		default: state <= ST_IDLE;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// protection override

// a reset drops the override, so no locked block opens by accident
always @(posedge SYS_CLK or negedge RST_B) begin
	if (!RST_B) begin
		override <= 1'b0;
	end else if (wr_reg && roff == `REG_CTRL_TWO && SEL_I[0]) begin
		override <= DAT_I[`OVERRIDE_BIT];
	end
end

////////////////////////////////////////////////////////////////////////
// wishbone answer, one wait-free cycle after the strobe

// ack: one pulse for every request taken
always @(posedge SYS_CLK or negedge RST_B) begin
	if (!RST_B) begin
		ACK_O <= 1'b0;
	end else begin
		ACK_O <= go;
	end
end

// read data is latched at the taking edge and holds until the next read
always @(posedge SYS_CLK or negedge RST_B) begin
	if (!RST_B) begin
		DAT_O <= 32'h0;
	end else begin
		if (go && !WE_I) begin
			if (ADR_I[`REG_SPACE_BIT]) begin
				case (roff)
				`REG_CTRL_TWO:   DAT_O <= {31'h0, override};
				`REG_READY_WORD: DAT_O <= {24'h0, ready_flag, 7'h0};
				`REG_ERROR_WORD: DAT_O <= {16'h0, error_word};
				default:         DAT_O <= 32'h0;
				endcase
			end else begin
				case (mode)
				// array contents live outside; erased pattern shown
				RD_ARRAY:  DAT_O <= 32'h0000ffff;
				RD_STATUS: DAT_O <= {16'h0, error_word};
				RD_LOCK:   DAT_O <= is_sel ? {16'h0, lock_word} : 32'h0;
				default:   DAT_O <= 32'h0;
				endcase
			end
		end
	end
end

endmodule
`default_nettype wire

// *** testbench/cpu_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_master (
	input wire logic        clk,
	input wire logic        ack,
	input wire logic [31:0] rdat,
	output logic            cyc,
	output logic            stb,
	output logic            we,
	output logic [31:0]     adr,
	output logic [31:0]     wdat,
	output logic [3:0]      sel
);
	initial begin
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 32'h0;
		wdat = 32'h0;
		sel = 4'h0;
	end
	////////////////////////////////////////////////////////////////
	// one classic cycle; released lines flip so stale values never match
	task xfer(input logic w, input logic [31:0] a, d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hf;
		@(posedge clk);
		while (ack !== 1'b1) @(posedge clk);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		adr <= ~a;
		wdat <= ~d;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** testbench/flash_lock_bit_sequencer_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "flash_lock_consts.vh"
module flash_lock_bit_sequencer_bench;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic cyc, stb, we, ack;
	logic [31:0] adr, wdat, rdat, v;
	logic [3:0] sel;
	int err_count = 0;
	int checked = 0;
	localparam logic [31:0] RG = 32'h0080_0000;
	localparam logic [31:0] B0 = {12'h0, `BLK0_LAST};
	localparam logic [31:0] B3 = {12'h0, `BLK3_LAST};
	localparam logic [31:0] B5 = {12'h0, `BLK5_LAST};
	always #12.5 sys_clk = ~sys_clk;
	cpu_master cpu_u (.clk(sys_clk), .ack(ack), .rdat(rdat), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
		.wdat(wdat), .sel(sel));
	// short busy counts keep the run brief
	flash_lock_bit_sequencer #(.PROG_CYCLES(22'd10), .ERASE_CYCLES(22'd20)) dut_u (.SYS_CLK(sys_clk),
		.RST_B(rst_b), .ADR_I(adr), .DAT_I(wdat), .SEL_I(sel), .WE_I(we), .CYC_I(cyc), .STB_I(stb),
		.DAT_O(rdat), .ACK_O(ack));
	////////////////////////////////////////////////////////////////
	task end_sim;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wr(input logic [31:0] a, input logic [15:0] d);
		cpu_u.xfer(1'b1, a, {16'h0, d}, v);
	endtask
	task rdc(input logic [31:0] a, e, input string n);
		cpu_u.xfer(1'b0, a, 32'h0, v);
		checked++;
		if (v !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, v);
		end
	endtask
	// poll ready under a bound
	task wait_rdy;
		v = 32'h0;
		for (int k = 0; k < 60 && v[7] !== 1'b1; k++) cpu_u.xfer(1'b0, RG + 32'h4, 32'h0, v);
		rdc(RG + 32'h4, 32'h80, "ready");
	endtask
	task op(input logic [15:0] c, input logic [31:0] a);
		wr(32'h0, c);
		wr(a, `CMD_VERIFY);
		wait_rdy();
	endtask
	task lk(input logic [31:0] a, e);
		wr(32'h0, `CMD_READ_LOCK);
		rdc(a, e, "lock");
	endtask
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		end_sim();
	end
	initial begin
		repeat (5) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		lk(B3, 32'h202);
		wr(32'h0, `CMD_READ_ARRAY);
		rdc(32'h100, 32'hffff, "array");
		wr(RG + 32'h4, 16'h0);
		rdc(RG + 32'h4, 32'h80, "ready ro");
		rdc(RG + 32'hc, 32'h0, "unmapped");
		wr(32'h0, `CMD_LOCK_PROG);
		wr(B3, `CMD_VERIFY);
		rdc(RG + 32'h4, 32'h0, "busy");
		wait_rdy();
		lk(B3, 32'h0);
		wr(32'h0, `CMD_PAGE_PROG);
		wr(32'h0000_f000, 16'h1234);
		wait_rdy();
		rdc(32'hf000, 32'h90, "status");
		op(`CMD_LOCK_PROG, B5);
		lk(B5, 32'h202);
		wr(32'h0, `CMD_CLEAR_STATUS);
		rdc(RG + 32'h8, 32'h80, "cleared");
		op(`CMD_BLOCK_ERASE, B3);
		rdc(RG + 32'h8, 32'ha0, "erase fail");
		lk(B3, 32'h0);
		wr(32'h0, `CMD_CLEAR_STATUS);
		wr(RG, 16'h1);
		rdc(RG, 32'h1, "override");
		op(`CMD_BLOCK_ERASE, B3);
		lk(B3, 32'h202);
		wr(32'h0, `CMD_LOCK_PROG);
		wr(32'h100, `CMD_VERIFY);
		wr(32'h0, `CMD_READ_STATUS);
		rdc(32'h100, 32'h88, "lock abort");
		wr(32'h0, `CMD_CLEAR_STATUS);
		wr(32'h0, `CMD_BLOCK_ERASE);
		wr(B5, 16'h1234);
		rdc(RG + 32'h8, 32'ha0, "erase abort");
		wr(32'h0, `CMD_CLEAR_STATUS);
		wr(32'h0, `CMD_BLOCK_ERASE);
		wr(B5, `CMD_READ_ARRAY);
		rdc(RG + 32'h8, 32'h80, "cancel");
		rdc(B5, 32'hffff, "array after cancel");
		op(`CMD_LOCK_PROG, B0);
		rst_b <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		lk(B0, 32'h0);
		rdc(RG, 32'h0, "override rst");
		wr(RG, 16'h1);
		op(`CMD_ERASE_ALL, 32'h0);
		lk(B0, 32'h202);
		end_sim();
	end
endmodule
bind flash_lock_bit_sequencer flash_lock_checker chk_u (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .ADR_I(ADR_I),
	.DAT_I(DAT_I), .SEL_I(SEL_I), .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .DAT_O(DAT_O), .ACK_O(ACK_O));
`default_nettype wire

// *** testbench/flash_lock_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_lock_checker (
	input wire logic        SYS_CLK,
	input wire logic        RST_B,
	input wire logic [31:0] ADR_I,
	input wire logic [31:0] DAT_I,
	input wire logic [3:0]  SEL_I,
	input wire logic        WE_I,
	input wire logic        CYC_I,
	input wire logic        STB_I,
	input wire logic [31:0] DAT_O,
	input wire logic        ACK_O
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	////////////////////////////////////////////////////////////////
	// bus answer timing
	property p_ack_next; CYC_I && STB_I && !ACK_O |=> ACK_O; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; ACK_O |=> !ACK_O; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_ack_cause; $rose(ACK_O) |-> $past(CYC_I) && $past(STB_I); endproperty
	a_ack_cause: assert property (p_ack_cause) else $error("ack unasked");
	// read data only moves on a read answer
	property p_dat_hold; !ACK_O |-> $stable(DAT_O); endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("data moved");
	property p_wr_hold; ACK_O && $past(WE_I) |-> $stable(DAT_O); endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write hit data");
	property p_copy; ACK_O |-> DAT_O[9] == DAT_O[1]; endproperty
	a_copy: assert property (p_copy) else $error("copy bit differs");
	property p_flash_hi; ACK_O && !$past(WE_I) && !$past(ADR_I[23]) |-> DAT_O[31:16] == 16'h0; endproperty
	a_flash_hi: assert property (p_flash_hi) else $error("upper half set");
	// ready word holds nothing but the ready flag
	property p_ready; ACK_O && !$past(WE_I) && $past(ADR_I[23]) && $past(ADR_I[7:0]) == 8'h04
		|-> (DAT_O & 32'hffffff7f) == 32'h0; endproperty
	a_ready: assert property (p_ready) else $error("ready word stray bits");
	c_flash_rd: cover property (ACK_O && !$past(WE_I) && !$past(ADR_I[23]));
	c_reg_rd: cover property (ACK_O && !$past(WE_I) && $past(ADR_I[23]));
	c_wr: cover property (ACK_O && $past(WE_I));
endmodule
`default_nettype wire
